//--- rtl/osc_consts.svh
/*
 Offsets, field positions, reset values and timing counts of the
 oscillator control and status block.
 Assumes a 10 MHz system clock and byte addresses on AXI4-Lite.
*/
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_OSC_CTRL     8'h00
`define OFS_CLK_DIV      8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_MASK     8'h0c
`define OFS_UNLOCK       8'h10
`define OFS_CFG_VIEW     8'h14

// ==========================================================
// Oscillator control and clock divide field positions
`define CUR_SRC_LSB      12
`define NEW_SRC_LSB      8
`define FREEZE_BIT       7
`define PIN_FREEZE_BIT   6
`define PLL_LOCK_BIT     5
`define FAIL_BIT         3
`define SLEEP_KEEP_BIT   2
`define SECONDARY_OSCILLATOR_EN_BIT      1
`define SWITCH_REQ_BIT   0
`define CLK_DIV_LSB      6

// ==========================================================
// Source encodings
`define SRC_FRC_POST     3'h7
`define SRC_RESERVED     3'h6
`define SRC_FRC_PLL      3'h1
`define SRC_PRI_PLL      3'h3

// ==========================================================
// Interrupt status bits and unlock keys
`define IRQ_DONE_BIT     0
`define IRQ_FAIL_BIT     1
`define IRQ_REFUSED_BIT  2
`define IRQ_RESET        3'h0
`define UNLOCK_KEY1      16'h0046
`define UNLOCK_KEY2      16'h0057

// ==========================================================
// Timing
`define CLK_PERIOD_NS    100
`define SWITCH_TIME_NS   2000
`define SWITCH_CYCLES    ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/osc_pkg.sv
/*
 Types shared by the oscillator control and status block.
 Assumes osc_consts.svh carries every number.
*/
package osc_pkg;

   // ==========================================================
   // Configuration bits; only the initial source is sampled at reset, the rest are read live
   typedef struct packed {
      logic [1:0] switch_monitor_cfg;
      logic       pin_lock_one_shot_cfg;
      logic [2:0] initial_source_cfg;
   } osc_cfg_t;

   // ==========================================================
   // Clock divide register, bits 15:6
   typedef struct packed {
      logic       recover_on_irq;
      logic [2:0] doze_ratio;
      logic       doze_enable;
      logic [2:0] fast_rc_postscale_select;
      logic [1:0] cpu_clock_divider;
   } clk_div_t;

   // ==========================================================
   // Switch sequencer states
   typedef enum logic [2:0] {
      SEQ_IDLE   = 3'b001,
      SEQ_SETTLE = 3'b010,
      SEQ_DONE   = 3'b100
   } seq_state_t;

endpackage

//--- rtl/switch_sequencer.sv
/*
 Clock switch sequencer: waits a settle time after a start pulse
 and then gives a one-cycle done pulse.
 Assumes start only arrives while busy is low.
*/
`include "osc_consts.svh"

module switch_sequencer #(
   parameter int SETTLE_CYCLES = `SWITCH_CYCLES
) (
   input  wire logic aclk,     // System clock
   input  wire logic aresetn,  // Synchronous reset, active low
   input  wire logic start,    // Begin a switch, one cycle
   output logic      busy_q,   // Switch under way
   output logic      done_q    // Switch complete, one cycle
);

   // Elaboration check: the down counter is only 16 bits wide
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
      $error("SETTLE_CYCLES out of range");
   end

   osc_pkg::seq_state_t state_q;
   logic [15:0]         count_q;

   // ==========================================================
   // Sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= osc_pkg::SEQ_IDLE;
         count_q <= 16'h0000;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            osc_pkg::SEQ_IDLE: begin
               if (start) begin
                  state_q <= osc_pkg::SEQ_SETTLE;
                  count_q <= 16'(SETTLE_CYCLES - 1);
                  busy_q  <= 1'b1;
               end
            end
            osc_pkg::SEQ_SETTLE: begin
               if (count_q == 16'h0000) begin
                  state_q <= osc_pkg::SEQ_DONE;
                  done_q  <= 1'b1;
               end else begin
                  count_q <= count_q - 16'h0001;
               end
            end
            osc_pkg::SEQ_DONE: begin
               state_q <= osc_pkg::SEQ_IDLE;
               busy_q  <= 1'b0;
            end
            default: begin
               state_q <= osc_pkg::SEQ_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

endmodule

//--- rtl/oscillator_control_status.sv
/*
 Oscillator control and status registers behind an AXI4-Lite slave:
 clock switch request and lock, pin mapping lock, PLL lock and clock
 fail flags, oscillator enables, doze and divider fields, interrupt.
 Assumes configuration bits are stable around reset and all inputs
 are synchronous to aclk.
*/
// Summary of operation
// - With the fail-safe monitor on, a set freeze bit blocks switches.
// - With the monitor off, switches are never locked by the freeze bit.
// - A pin map freeze of 1 makes the I/O mapping lock active.
// - Pin map freeze changes only after the unlock key sequence.
// - With the one-shot config set, a set pin map freeze stays set.
// - PLL lock reads 1 when the PLL locked or its timer expired.
// - PLL lock reads 0 during a switch and in modes without the PLL.
// - The fail flag is set when the monitor detects a clock failure.
// - Sleep keeps the primary oscillator only if sleep-keep is 1.
// - The secondary oscillator runs while its enable bit is 1.
// - Writing 1 to the switch request starts a switch; it clears when done.
// - Reset loads the new source from the initial source config bits.
// - The current source reports the 3-bit source encoding.
// - Switching needs config upper bit 0; monitor needs both bits 0.
// - With recover-on-irq set, an interrupt clears doze enable.
`include "osc_consts.svh"

module oscillator_control_status #(
   parameter int SETTLE_CYCLES = `SWITCH_CYCLES
) (
   input  wire logic              aclk,           // System clock
   input  wire logic              aresetn,        // Sync reset, low
   input  wire osc_pkg::osc_cfg_t cfg,            // Config bits
   input  wire logic              pll_locked,     // PLL in lock
   input  wire logic              pll_timer_done, // PLL timer expired
   input  wire logic              clock_fail,     // Monitor saw failure
   input  wire logic              irq_event,      // Any CPU interrupt
   input  wire logic              sleep_mode,     // Device in Sleep
   output logic [2:0]             cur_source_q,   // Active source
   output logic                   pll_enable_q,   // PLL in use
   output logic                   pri_osc_run_q,  // Primary osc on
   output logic                   sec_osc_run_q,  // Secondary osc on
   output logic                   pin_lock_q,     // I/O map locked
   output osc_pkg::clk_div_t      clk_div_q,      // Divide fields
   output logic                   irq_q,          // Interrupt, level
   input  wire logic [7:0]        s_awaddr,       // AXI write address
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,        // AXI write data
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,        // AXI write response
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [7:0]        s_araddr,       // AXI read address
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,        // AXI read data
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready
);

   // Elaboration check: a zero settle time would wrap the settle count to 65535
   if (SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("SETTLE_CYCLES must be at least 1");
   end

   function automatic logic uses_pll(input logic [2:0] src);
      uses_pll = (src == `SRC_PRI_PLL) || (src == `SRC_FRC_PLL);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `OFS_OSC_CTRL) || (a == `OFS_CLK_DIV) ||
               (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK) ||
               (a == `OFS_UNLOCK) || (a == `OFS_CFG_VIEW);
   endfunction

   // ==========================================================
   // AXI4-Lite write channels
   logic        aw_have_q, w_have_q, aw_have_d, w_have_d;
   logic [7:0]  wa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic        aw_hs, w_hs, do_write;

   assign aw_hs     = s_awvalid & s_awready;
   assign w_hs      = s_wvalid & s_wready;
   assign do_write  = aw_have_q & w_have_q & ~s_bvalid;
   assign aw_have_d = (aw_have_q | aw_hs) & ~do_write;
   assign w_have_d  = (w_have_q | w_hs) & ~do_write;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         wa_q      <= 8'h00;
         wd_q      <= 32'h0000_0000;
         ws_q      <= 4'h0;
         s_bvalid  <= 1'b0;
         s_bresp   <= 2'h0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         s_awready <= ~aw_have_d;
         s_wready  <= ~w_have_d;
         if (aw_hs) begin
            wa_q <= s_awaddr;
         end
         if (w_hs) begin
            wd_q <= s_wdata;
            ws_q <= s_wstrb;
         end
         if (do_write) begin
            s_bvalid <= 1'b1;
            s_bresp  <= mapped(wa_q) ? 2'h0 : 2'h3;
         end else if (s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   logic lane0, lane1;
   assign lane0 = ws_q[0];
   assign lane1 = ws_q[1];

   // ==========================================================
   // Lock and permission terms
   logic fsm_enabled, switch_allowed, switch_locked;
   logic freeze_q, pin_freeze_q, fail_q, sleep_keep_q, secondary_oscillator_en_q;
   logic req_q, pll_lock_q;
   logic [2:0] new_source_q;
   logic [2:0] irq_status_q, irq_mask_q;
   logic       seq_busy, seq_done;

   assign fsm_enabled    = (cfg.switch_monitor_cfg == 2'h0);
   assign switch_allowed = ~cfg.switch_monitor_cfg[1];
   // Freeze only bites with the monitor on
   assign switch_locked  = fsm_enabled & freeze_q;

   logic ctrl_wr, div_wr;
   assign ctrl_wr = do_write && (wa_q == `OFS_OSC_CTRL);
   assign div_wr  = do_write && (wa_q == `OFS_CLK_DIV);

   logic req_write, start, refused;
   assign req_write = ctrl_wr & lane0 & wd_q[`SWITCH_REQ_BIT];
   assign start     = req_write & switch_allowed & ~switch_locked &
                      ~req_q & ~seq_busy &
                      (new_source_q != `SRC_RESERVED);
   assign refused   = req_write & ~start & ~req_q;

   // ==========================================================
   // Unlock sequence for the pin map freeze
   logic key1_seen_q, unlock_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key1_seen_q <= 1'b0;
         unlock_q    <= 1'b0;
      end else if (do_write) begin
         // Keys must be back to back; the window lasts one write
         key1_seen_q <= (wa_q == `OFS_UNLOCK) &&
                        (wd_q[15:0] == `UNLOCK_KEY1);
         unlock_q    <= key1_seen_q && (wa_q == `OFS_UNLOCK) &&
                        (wd_q[15:0] == `UNLOCK_KEY2);
      end
   end

   // ==========================================================
   // Oscillator control fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         new_source_q <= cfg.initial_source_cfg;
         freeze_q     <= 1'b0;
         sleep_keep_q <= 1'b0;
         secondary_oscillator_en_q    <= 1'b0;
      end else if (ctrl_wr) begin
         if (lane1 && !switch_locked && !req_q) begin
            new_source_q <= wd_q[`NEW_SRC_LSB +: 3];
         end
         if (lane0) begin
            // Set only: software cannot undo the freeze
            freeze_q     <= freeze_q | wd_q[`FREEZE_BIT];
            sleep_keep_q <= wd_q[`SLEEP_KEEP_BIT];
            secondary_oscillator_en_q    <= wd_q[`SECONDARY_OSCILLATOR_EN_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_freeze_q <= 1'b0;
      end else if (ctrl_wr && lane0 && unlock_q) begin
         // One-shot config keeps a set lock until reset
         if (!(cfg.pin_lock_one_shot_cfg && pin_freeze_q)) begin
            pin_freeze_q <= wd_q[`PIN_FREEZE_BIT];
         end
      end
   end

   // Clear-only by software; a failure in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fail_q <= 1'b0;
      end else if (clock_fail && fsm_enabled) begin
         fail_q <= 1'b1;
      end else if (ctrl_wr && lane0 && !wd_q[`FAIL_BIT]) begin
         fail_q <= 1'b0;
      end
   end

   // ==========================================================
   // Switch request and completion
   switch_sequencer #(
      .SETTLE_CYCLES (SETTLE_CYCLES)
   ) u_seq (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (start),
      .busy_q  (seq_busy),
      .done_q  (seq_done)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q        <= 1'b0;
         cur_source_q <= cfg.initial_source_cfg;
      end else if (seq_done) begin
         req_q        <= 1'b0;
         cur_source_q <= new_source_q;
      end else if (start) begin
         req_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_lock_q <= 1'b0;
      end else begin
         pll_lock_q <= uses_pll(cur_source_q) & ~seq_busy &
                       (pll_locked | pll_timer_done);
      end
   end

   // ==========================================================
   // Clock divide register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_div_q <= '0;
      end else begin
         if (div_wr) begin
            if (lane1) begin
               clk_div_q[9:2] <= wd_q[15:8];
            end
            if (lane0) begin
               clk_div_q.cpu_clock_divider <= wd_q[7:6];
            end
         end
         // Interrupt recovery beats a software write of doze enable
         if (irq_event && clk_div_q.recover_on_irq) begin
            clk_div_q.doze_enable <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Interrupt status, mask and output
   logic [2:0] irq_set;
   assign irq_set = {refused, clock_fail & fsm_enabled, seq_done};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= `IRQ_RESET;
         irq_mask_q   <= `IRQ_RESET;
         irq_q        <= 1'b0;
      end else begin
         // Set wins over a write-one clear in the same cycle
         if (do_write && wa_q == `OFS_IRQ_STATUS && lane0) begin
            irq_status_q <= (irq_status_q & ~wd_q[2:0]) | irq_set;
         end else begin
            irq_status_q <= irq_status_q | irq_set;
         end
         if (do_write && wa_q == `OFS_IRQ_MASK && lane0) begin
            irq_mask_q <= wd_q[2:0];
         end
         irq_q <= |(irq_status_q & irq_mask_q);
      end
   end

   // ==========================================================
   // Clock enables seen by the oscillators, and the I/O map lock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pri_osc_run_q <= 1'b1;
         sec_osc_run_q <= 1'b0;
         pin_lock_q    <= 1'b0;
         pll_enable_q  <= 1'b0;
      end else begin
         pri_osc_run_q <= ~sleep_mode | sleep_keep_q;
         sec_osc_run_q <= secondary_oscillator_en_q;
         pin_lock_q    <= pin_freeze_q;
         pll_enable_q  <= uses_pll(cur_source_q);
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] rd_mux;
   logic        ar_hs, rvalid_d;

   assign ar_hs    = s_arvalid & s_arready;
   assign rvalid_d = ar_hs | (s_rvalid & ~s_rready);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_araddr)
         `OFS_OSC_CTRL: begin
            rd_mux[`CUR_SRC_LSB +: 3] = cur_source_q;
            rd_mux[`NEW_SRC_LSB +: 3] = new_source_q;
            rd_mux[`FREEZE_BIT]       = freeze_q;
            rd_mux[`PIN_FREEZE_BIT]   = pin_freeze_q;
            rd_mux[`PLL_LOCK_BIT]     = pll_lock_q;
            rd_mux[`FAIL_BIT]         = fail_q;
            rd_mux[`SLEEP_KEEP_BIT]   = sleep_keep_q;
            rd_mux[`SECONDARY_OSCILLATOR_EN_BIT]      = secondary_oscillator_en_q;
            rd_mux[`SWITCH_REQ_BIT]   = req_q;
         end
         `OFS_CLK_DIV:    rd_mux[15:`CLK_DIV_LSB] = clk_div_q;
         `OFS_IRQ_STATUS: rd_mux[2:0] = irq_status_q;
         `OFS_IRQ_MASK:   rd_mux[2:0] = irq_mask_q;
         `OFS_CFG_VIEW:   rd_mux[5:0] = cfg;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= 2'h0;
      end else begin
         s_arready <= ~rvalid_d;
         s_rvalid  <= rvalid_d;
         if (ar_hs) begin
            s_rdata <= rd_mux;
            s_rresp <= mapped(s_araddr) ? 2'h0 : 2'h3;
         end
      end
   end

endmodule

//--- verif/osc_ctrl_asserts.sv
/*
 Concurrent checks for the oscillator control block.
 Assumes it is bound into oscillator_control_status and sees its ports.
*/
`include "osc_consts.svh"

module osc_ctrl_asserts (
   input wire logic              aclk,          // Clock
   input wire logic              aresetn,       // Reset, low
   input wire osc_pkg::osc_cfg_t cfg,           // Config bits
   input wire logic              sleep_mode,    // Sleep
   input wire logic              irq_event,     // Interrupt
   input wire logic [2:0]        cur_source_q,  // Active source
   input wire logic              pll_enable_q,  // PLL in use
   input wire logic              pri_osc_run_q, // Primary on
   input wire logic              pin_lock_q,    // Map lock
   input wire osc_pkg::clk_div_t clk_div_q,     // Divide fields
   input wire logic              s_arvalid,     // Read valid
   input wire logic              s_arready,     // Read ready
   input wire logic [7:0]        s_araddr,      // Read address
   input wire logic [31:0]       s_rdata        // Read data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic rd_ctrl;
   assign rd_ctrl = s_arvalid && s_arready && s_araddr == `OFS_OSC_CTRL;

   // ==============================
   // Assertions
   chk_reset_load: assert property (
      $rose(aresetn) |-> cur_source_q == cfg.initial_source_cfg)
      else $error("source not loaded from config at reset");
   chk_sleep_awake: assert property (
      !$past(sleep_mode) |-> pri_osc_run_q)
      else $error("primary oscillator stopped while awake");
   chk_pin_one_shot: assert property (
      cfg.pin_lock_one_shot_cfg && pin_lock_q |=> pin_lock_q)
      else $error("one-shot pin lock was cleared");
   chk_doze_clear: assert property (
      irq_event && clk_div_q.recover_on_irq |=> !clk_div_q.doze_enable)
      else $error("interrupt left doze enabled");
   chk_switch_cfg: assert property (
      $changed(cur_source_q) |-> !cfg.switch_monitor_cfg[1])
      else $error("source changed with switching disabled");
   chk_read_source: assert property (
      rd_ctrl |=> s_rdata[14:12] == $past(cur_source_q))
      else $error("read source differs from active source");
   chk_read_pll_off: assert property (
      ($stable(cur_source_q) [*2] ##0 (rd_ctrl && !pll_enable_q))
      |=> !s_rdata[5])
      else $error("PLL lock reads set in a non-PLL mode");
   chk_read_pin: assert property (
      rd_ctrl |=> s_rdata[6] == pin_lock_q)
      else $error("pin freeze bit and lock output disagree");

   // ==============================
   // Coverage
   cover property ($changed(cur_source_q));
   cover property ($rose(pin_lock_q));
   cover property (irq_event && clk_div_q.recover_on_irq);
endmodule

//--- verif/oscillator_control_status_tb_top.sv
/*
 Self-checking bench for the oscillator control block.
 Assumes the checker module is compiled before this file.
*/
`include "osc_consts.svh"

module oscillator_control_status_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SETTLE = 6;

   typedef struct packed {
      logic [7:0]  a;
      logic [15:0] d;
      logic [31:0] e;
      logic [1:0]  r;
   } row_t;

   osc_pkg::osc_cfg_t cfg;
   osc_pkg::clk_div_t clk_div_q;
   logic aclk, aresetn, pll_locked, pll_timer_done, clock_fail;
   logic irq_event, sleep_mode, s_awvalid, s_wvalid, s_bready;
   logic s_arvalid, s_rready, pll_enable_q, pri_osc_run_q;
   logic sec_osc_run_q, pin_lock_q, irq_q, s_awready, s_wready;
   logic s_bvalid, s_arready, s_rvalid;
   logic [2:0] cur_source_q;
   logic [1:0] s_bresp, s_rresp, br, rr;
   logic [3:0] s_wstrb;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rdat;
   int bad_count, checked, n;
   row_t rows [7] = '{'{8'h04, 16'hffc0, 32'hffc0, 2'h0},
      '{8'h0c, 16'h0007, 32'h7, 2'h0}, '{8'h00, 16'h0206, 32'h2206, 2'h0},
      '{8'h10, 16'h1234, 32'h0, 2'h0}, '{8'h14, 16'h003f, 32'h0a, 2'h0},
      '{8'h08, 16'h0007, 32'h0, 2'h0}, '{8'h3c, 16'h1111, 32'h0, 2'h3}};

   oscillator_control_status #(.SETTLE_CYCLES(SETTLE)) dut_u (
      .aclk, .aresetn, .cfg, .pll_locked, .pll_timer_done, .clock_fail,
      .irq_event, .sleep_mode, .cur_source_q, .pll_enable_q,
      .pri_osc_run_q, .sec_osc_run_q, .pin_lock_q, .clk_div_q, .irq_q,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // ==============================
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // Either channel may be taken first; each drops on its own ready
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_awaddr <= a;
      s_wdata <= {16'h0000, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | s_awready;
         w = w | s_wready;
         s_awvalid <= !aw;
         s_wvalid <= !w;
      end
      do @(posedge aclk); while (!s_bvalid);
      br = s_bresp;
   endtask

   task automatic rdr(input logic [7:0] a);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_arready);
      s_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_rvalid);
      rdat = s_rdata;
      rr = s_rresp;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
      rdr(a);
      check(rdat & m, e);
   endtask

   task automatic unlock;
      wr(`OFS_UNLOCK, `UNLOCK_KEY1);
      wr(`OFS_UNLOCK, `UNLOCK_KEY2);
   endtask

   task automatic do_reset(input logic [5:0] c);
      aresetn <= 1'b0;
      cfg <= c;
      tick(2);
      aresetn <= 1'b1;
      tick(1);
   endtask

   task automatic wait_src(input logic [2:0] s);
      n = 0;
      while (cur_source_q !== s && n < 60) begin
         @(posedge aclk);
         n++;
      end
   endtask

   task automatic final_report;
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ==============================
   // Stimulus
   initial begin
      {pll_locked, pll_timer_done, clock_fail, irq_event} = 4'h0;
      {sleep_mode, s_awvalid, s_wvalid, s_arvalid} = 4'h0;
      {s_bready, s_rready, s_wstrb} = 6'h33;
      {s_awaddr, s_araddr, s_wdata} = '0;
      bad_count = 0;
      checked = 0;
      do_reset(6'h0a);
      check(cur_source_q, 3'h2);
      check({pri_osc_run_q, sec_osc_run_q, irq_q, pin_lock_q}, 4'h8);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         check(br, rows[i].r);
         rdr(rows[i].a);
         check(rdat, rows[i].e);
         check(rr, rows[i].r);
      end
      check(clk_div_q, 10'h3ff);
      check({pri_osc_run_q, sec_osc_run_q}, 2'h3);
      $display("test register table done");
      sleep_mode <= 1'b1;
      tick(2);
      check(pri_osc_run_q, 1'b1);
      wr(`OFS_OSC_CTRL, 16'h0200);
      tick(2);
      check({pri_osc_run_q, sec_osc_run_q}, 2'h0);
      sleep_mode <= 1'b0;
      irq_event <= 1'b1;
      tick(1);
      irq_event <= 1'b0;
      tick(1);
      check(clk_div_q, 10'h3df);
      wr(`OFS_CLK_DIV, 16'h7fc0);
      irq_event <= 1'b1;
      tick(1);
      irq_event <= 1'b0;
      tick(1);
      check(clk_div_q, 10'h1ff);
      $display("test sleep and doze done");
      pll_locked <= 1'b1;
      wr(`OFS_OSC_CTRL, 16'h0300);
      wr(`OFS_OSC_CTRL, 16'h0301);
      rchk(`OFS_OSC_CTRL, 32'h1, 32'h1);
      wait_src(3'h3);
      check(cur_source_q, 3'h3);
      rchk(`OFS_OSC_CTRL, 32'h7021, 32'h3020);
      check(pll_enable_q, 1'b1);
      pll_locked <= 1'b0;
      tick(3);
      rchk(`OFS_OSC_CTRL, 32'h20, 32'h0);
      pll_timer_done <= 1'b1;
      tick(3);
      rchk(`OFS_OSC_CTRL, 32'h20, 32'h20);
      pll_timer_done <= 1'b0;
      check(irq_q, 1'b1);
      wr(`OFS_IRQ_STATUS, 16'h0001);
      tick(2);
      check(irq_q, 1'b0);
      $display("test switch done");
      wr(`OFS_IRQ_MASK, 16'h0000);
      clock_fail <= 1'b1;
      tick(1);
      clock_fail <= 1'b0;
      tick(2);
      rchk(`OFS_OSC_CTRL, 32'h8, 32'h8);
      check(irq_q, 1'b0);
      wr(`OFS_IRQ_MASK, 16'h0002);
      tick(2);
      check(irq_q, 1'b1);
      $display("test clock fail done");
      // Freeze with monitor on: request must be refused
      wr(`OFS_OSC_CTRL, 16'h0380);
      wr(`OFS_OSC_CTRL, 16'h0081);
      tick(20);
      check(cur_source_q, 3'h3);
      rchk(`OFS_IRQ_STATUS, 32'h4, 32'h4);
      wr(`OFS_OSC_CTRL, 16'h00c0);
      tick(2);
      check(pin_lock_q, 1'b0);
      unlock;
      wr(`OFS_OSC_CTRL, 16'h00c0);
      tick(2);
      check(pin_lock_q, 1'b1);
      unlock;
      wr(`OFS_OSC_CTRL, 16'h0080);
      tick(2);
      check(pin_lock_q, 1'b1);
      $display("test locks done");
      do_reset(6'h17);
      check(cur_source_q, 3'h7);
      check(pll_enable_q, 1'b0);
      wr(`OFS_OSC_CTRL, 16'h0080);
      wr(`OFS_OSC_CTRL, 16'h0081);
      wait_src(3'h0);
      check(cur_source_q, 3'h0);
      do_reset(6'h25);
      wr(`OFS_OSC_CTRL, 16'h0001);
      tick(20);
      check(cur_source_q, 3'h5);
      rchk(`OFS_IRQ_STATUS, 32'h4, 32'h4);
      $display("test config modes done");
      final_report;
   end

   initial begin
      #(100 * 4000);
      bad_count++;
      final_report;
   end
endmodule

bind oscillator_control_status osc_ctrl_asserts chk_u (
   .aclk, .aresetn, .cfg, .sleep_mode, .irq_event, .cur_source_q,
   .pll_enable_q, .pri_osc_run_q, .pin_lock_q, .clk_div_q, .s_arvalid,
   .s_arready, .s_araddr, .s_rdata);
